// [design/ccg_map.svh]
`ifndef CCG_MAP_SVH
`define CCG_MAP_SVH
`define CCG_AW 12
`define CCG_OFF_STS 12'h284
`define CCG_OFF_CEN 12'h290
`define CCG_OFF_IEN 12'h2b0
`define CCG_OFF_ICLR 12'h2b4
`define CCG_B_TXC 29
`define CCG_B_FS 31
`define CCG_B_ROOT 0
`define CCG_B_BCLK 1
`define CCG_B_FSEN 2
`define CCG_B_EDGE 3
`define CCG_CEN_W 4
`define CCG_CEN_RST 4'h0
`define CCG_EV_W 2
`define CCG_EV_TXC 0
`define CCG_EV_FS 1
`define CCG_EV_RST 2'h0
`define CCG_ZERO32 32'h0000_0000
`endif

// [design/ccg_pkg.sv]
package ccg_pkg;
  // raw timing signals from the divider domain and the pin
  typedef struct packed {
    logic root;
    logic bclk;
    logic fsync_div;
    logic fsync_pin;
  } ccg_wave_type;
  typedef enum logic [3:0] {
    FS_STOPPED  = 4'h1,
    FS_STARTING = 4'h2,
    FS_RUNNING  = 4'h4,
    FS_STOPPING = 4'h8
  } ccg_fs_state_type;
endpackage

// [design/ccg_top.sv]
`timescale 1ns/1ps
`include "ccg_map.svh"

module ccg_top #(
  parameter int DATA_W = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`CCG_AW-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  input wire ccg_pkg::ccg_wave_type wave_in,
  input wire logic bclk_is_output,
  input wire logic fsync_is_output,
  input wire logic bclk_stop_level,
  input wire logic fsync_stop_level,
  input wire logic tx_fifo_empty,
  input wire logic tx_dma_mode,
  input wire logic tx_dma_done,
  output logic root_clk_gated,
  output logic bclk_out,
  output logic fsync_out,
  output logic irq
);

  if (DATA_W != 32) begin : g_chk
    $error("ccg_top: DATA_W must be 32");
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  ccg_pkg::ccg_wave_type meta_reg;
  ccg_pkg::ccg_wave_type wave_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      wave_reg <= '0;
    end else begin
      meta_reg <= wave_in;
      wave_reg <= meta_reg;
    end
  end

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  logic [`CCG_CEN_W-1:0] cen_reg;
  logic [`CCG_EV_W-1:0] ien_reg;
  logic [`CCG_EV_W-1:0] sts_reg;
  logic [`CCG_EV_W-1:0] sts_next;
  logic [`CCG_EV_W-1:0] clr_mask;
  logic [`CCG_EV_W-1:0] ev;
  logic [DATA_W-1:0] rdata_reg;

  wire wr_sts = wr && (addr == `CCG_OFF_STS);
  wire wr_cen = wr && (addr == `CCG_OFF_CEN);
  wire wr_ien = wr && (addr == `CCG_OFF_IEN);
  wire wr_clr = wr && (addr == `CCG_OFF_ICLR);

  // only the implemented bits are kept, the rest are dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      cen_reg <= `CCG_CEN_RST;
    end else if (wr_cen) begin
      cen_reg <= wdata[`CCG_CEN_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ien_reg <= `CCG_EV_RST;
    end else if (wr_ien) begin
      ien_reg <= {wdata[`CCG_B_FS], wdata[`CCG_B_TXC]};
    end
  end

  // status word and clear alias share one bit layout
  always_comb begin
    clr_mask = `CCG_EV_RST;
    if (wr_sts || wr_clr) begin
      clr_mask = {wdata[`CCG_B_FS], wdata[`CCG_B_TXC]};
    end
    // a new event wins over a clear in the same cycle
    sts_next = (sts_reg & ~clr_mask) | ev;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sts_reg <= `CCG_EV_RST;
    end else begin
      sts_reg <= sts_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(sts_next & (wr_ien ? {wdata[`CCG_B_FS], wdata[`CCG_B_TXC]} : ien_reg));
    end
  end

  always_comb begin
    rdata_reg = `CCG_ZERO32;
    case (addr)
      `CCG_OFF_STS: begin
        rdata_reg[`CCG_B_TXC] = sts_reg[`CCG_EV_TXC];
        rdata_reg[`CCG_B_FS] = sts_reg[`CCG_EV_FS];
      end
      `CCG_OFF_CEN: begin
        rdata_reg[`CCG_CEN_W-1:0] = cen_reg;
      end
      `CCG_OFF_IEN: begin
        rdata_reg[`CCG_B_TXC] = ien_reg[`CCG_EV_TXC];
        rdata_reg[`CCG_B_FS] = ien_reg[`CCG_EV_FS];
      end
      default: rdata_reg = `CCG_ZERO32;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= `CCG_ZERO32;
    end else begin
      rdata <= rd ? rdata_reg : `CCG_ZERO32;
    end
  end

  // ----------------------------------------
  // status events
  // ----------------------------------------
  logic txc_cond;
  logic txc_prev_reg;
  logic fs_line;
  logic fs_prev_reg;
  logic fs_edge;

  // in dma mode the fifo alone running dry is an underrun, not the end
  assign txc_cond = tx_dma_mode ? (tx_fifo_empty && tx_dma_done)
                                : tx_fifo_empty;

  always_ff @(posedge clk) begin
    if (rst) begin
      txc_prev_reg <= 1'b1;
    end else begin
      txc_prev_reg <= txc_cond;
    end
  end

  // watch the line as the codec sees it
  assign fs_line = fsync_is_output ? fsync_out : wave_reg.fsync_pin;

  always_ff @(posedge clk) begin
    if (rst) begin
      fs_prev_reg <= 1'b0;
    end else begin
      fs_prev_reg <= fs_line;
    end
  end

  assign fs_edge = cen_reg[`CCG_B_EDGE] ? (fs_prev_reg && !fs_line)
                                        : (!fs_prev_reg && fs_line);

  assign ev[`CCG_EV_TXC] = txc_cond && !txc_prev_reg;
  assign ev[`CCG_EV_FS] = fs_edge;

  // ----------------------------------------
  // root clock gate
  // ----------------------------------------
  logic root_run_reg;
  logic root_run_next;

  // the run flag only changes while the root clock is low
  always_comb begin
    root_run_next = root_run_reg;
    if (!wave_reg.root) begin
      root_run_next = cen_reg[`CCG_B_ROOT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      root_run_reg <= 1'b0;
      root_clk_gated <= 1'b0;
    end else begin
      root_run_reg <= root_run_next;
      root_clk_gated <= root_run_next && wave_reg.root;
    end
  end

  // ----------------------------------------
  // bit clock gate
  // ----------------------------------------
  logic bclk_run_reg;
  logic bclk_run_next;

  // switching only at the stop level keeps every pulse full width
  always_comb begin
    bclk_run_next = bclk_run_reg;
    if (bclk_is_output && (wave_reg.bclk == bclk_stop_level)) begin
      bclk_run_next = cen_reg[`CCG_B_BCLK];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bclk_run_reg <= 1'b0;
      bclk_out <= 1'b0;
    end else begin
      bclk_run_reg <= bclk_run_next;
      bclk_out <= bclk_run_next ? wave_reg.bclk : bclk_stop_level;
    end
  end

  // ----------------------------------------
  // frame sync gate
  // ----------------------------------------
  ccg_pkg::ccg_fs_state_type fs_state_reg;
  ccg_pkg::ccg_fs_state_type fs_state_next;
  logic fs_at_stop;
  logic fs_en;

  assign fs_at_stop = (wave_reg.fsync_div == fsync_stop_level);
  assign fs_en = cen_reg[`CCG_B_FSEN];

  always_comb begin
    fs_state_next = fs_state_reg;
    case (fs_state_reg)
      ccg_pkg::FS_STOPPED: begin
        if (fs_en && fsync_is_output) begin
          fs_state_next = fs_at_stop ? ccg_pkg::FS_RUNNING : ccg_pkg::FS_STARTING;
        end
      end
      ccg_pkg::FS_STARTING: begin
        if (!fs_en) begin
          fs_state_next = ccg_pkg::FS_STOPPED;
        end else if (fs_at_stop) begin
          fs_state_next = ccg_pkg::FS_RUNNING;
        end
      end
      ccg_pkg::FS_RUNNING: begin
        if (!fs_en && fsync_is_output) begin
          fs_state_next = fs_at_stop ? ccg_pkg::FS_STOPPED : ccg_pkg::FS_STOPPING;
        end
      end
      ccg_pkg::FS_STOPPING: begin
        if (fs_en) begin
          fs_state_next = ccg_pkg::FS_RUNNING;
        end else if (fs_at_stop) begin
          fs_state_next = ccg_pkg::FS_STOPPED;
        end
      end
      default: begin
        fs_state_next = ccg_pkg::FS_STOPPED;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fs_state_reg <= ccg_pkg::FS_STOPPED;
    end else begin
      fs_state_reg <= fs_state_next;
    end
  end

  // while the gate is stopped or starting the line is pinned at the stop level
  always_ff @(posedge clk) begin
    if (rst) begin
      fsync_out <= 1'b0;
    end else if (fs_state_next == ccg_pkg::FS_RUNNING ||
                 fs_state_next == ccg_pkg::FS_STOPPING) begin
      fsync_out <= wave_reg.fsync_div;
    end else begin
      fsync_out <= fsync_stop_level;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_txc_set;
    @(posedge clk) disable iff (rst)
      (txc_cond && !txc_prev_reg) |=> sts_reg[`CCG_EV_TXC];
  endproperty
  a_txc_set: assert property (p_txc_set) else $error("txc not set");
  property p_txc_dma;
    @(posedge clk) disable iff (rst)
      (tx_dma_mode && !tx_dma_done && !sts_reg[`CCG_EV_TXC]) |=> !sts_reg[`CCG_EV_TXC];
  endproperty
  a_txc_dma: assert property (p_txc_dma) else $error("txc set early");
  property p_w1c;
    @(posedge clk) disable iff (rst)
      ((wr_sts || wr_clr) && wdata[`CCG_B_FS] && !fs_edge) |=> !sts_reg[`CCG_EV_FS] &&
        (irq == (sts_reg[`CCG_EV_TXC] && ien_reg[`CCG_EV_TXC]));
  endproperty
  a_w1c: assert property (p_w1c) else $error("fs not cleared");
  property p_fs_edge;
    @(posedge clk) disable iff (rst)
      (cen_reg[`CCG_B_EDGE] && fs_prev_reg && !fs_line) |=> sts_reg[`CCG_EV_FS];
  endproperty
  a_fs_edge: assert property (p_fs_edge) else $error("falling edge missed");
  property p_root_low;
    @(posedge clk) disable iff (rst)
      !root_run_reg |-> !root_clk_gated;
  endproperty
  a_root_low: assert property (p_root_low) else $error("root not low");
  property p_root_cut;
    @(posedge clk) disable iff (rst)
      (root_run_reg != root_run_next) |-> !wave_reg.root;
  endproperty
  a_root_cut: assert property (p_root_cut) else $error("root cut high");
  property p_bclk_stop;
    @(posedge clk) disable iff (rst)
      !bclk_run_next |=> bclk_out == $past(bclk_stop_level);
  endproperty
  a_bclk_stop: assert property (p_bclk_stop) else $error("bclk not held");
  property p_bclk_mode;
    @(posedge clk) disable iff (rst)
      !bclk_is_output |=> bclk_run_reg == $past(bclk_run_reg);
  endproperty
  a_bclk_mode: assert property (p_bclk_mode) else $error("bclk gate moved");
  property p_fs_wait;
    @(posedge clk) disable iff (rst)
      (fs_state_reg == ccg_pkg::FS_STARTING && fs_en && !fs_at_stop)
        |=> fs_state_reg == ccg_pkg::FS_STARTING;
  endproperty
  a_fs_wait: assert property (p_fs_wait) else $error("fs started early");
  property p_fs_halt;
    @(posedge clk) disable iff (rst)
      (fs_state_reg == ccg_pkg::FS_STOPPING && !fs_en && !fs_at_stop)
        |=> fs_state_reg != ccg_pkg::FS_STOPPED;
  endproperty
  a_fs_halt: assert property (p_fs_halt) else $error("fs cut short");
  property p_fs_level;
    @(posedge clk) disable iff (rst)
      (fs_state_next == ccg_pkg::FS_STOPPED) |=> fsync_out == $past(fsync_stop_level);
  endproperty
  a_fs_level: assert property (p_fs_level) else $error("fs stop level");
  property p_rsvd;
    @(posedge clk) disable iff (rst)
      (rd && addr == `CCG_OFF_CEN) |=> rdata[DATA_W-1:`CCG_CEN_W] == '0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");

endmodule

// [verification/ccg_codec_model.sv]
`timescale 1ns/1ps
// ------------------------------------------
// free-running divider waves and codec pin
// ------------------------------------------
module ccg_codec_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic fs_level,
  output ccg_pkg::ccg_wave_type wave
);
  logic [7:0] cnt_reg;
  logic pin_reg;
  // divider runs free, so the gates see real clocks while stopped
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
  // codec launches frame sync from its own flop
  always_ff @(posedge clk) begin
    pin_reg <= fs_level;
  end
  assign wave = '{root: cnt_reg[1], bclk: cnt_reg[2], fsync_div: cnt_reg[4], fsync_pin: pin_reg};
endmodule

// [verification/testbench.sv]
`timescale 1ns/1ps
`include "ccg_map.svh"
`define check_eq(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0, rd = 1'b0, bdir = 1'b0, fdir = 1'b0, bstop = 1'b1, fstop = 1'b0;
  logic empty = 1'b0, dmode = 1'b0, ddone = 1'b0, lvl = 1'b0;
  logic [31:0] rdata;
  ccg_pkg::ccg_wave_type wave;
  logic root_g, bclk_g, fs_g, irq, rq, bq, fq;
  logic [31:0] sts = 32'h0, ien = 32'h0, cen = 32'h0;
  logic [11:0] offs[5] = '{`CCG_OFF_STS, `CCG_OFF_CEN, `CCG_OFF_IEN, `CCG_OFF_ICLR, 12'h100};
  int fail_count = 0, checks = 0, cyc = 0, r_rise, b_rise, f_rise, b_hi, f_hi;
  int root_hi = 0, fs_run = -1;

  ccg_codec_model i_ccg_codec_model (.clk(clk), .rst(rst), .fs_level(lvl), .wave(wave));
  ccg_top i_ccg_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .wave_in(wave), .bclk_is_output(bdir), .fsync_is_output(fdir),
    .bclk_stop_level(bstop), .fsync_stop_level(fstop), .tx_fifo_empty(empty),
    .tx_dma_mode(dmode), .tx_dma_done(ddone), .root_clk_gated(root_g), .bclk_out(bclk_g),
    .fsync_out(fs_g), .irq(irq));

  always #50 clk = ~clk;

  // ------------------------------------------
  // output monitor, sampled away from the launching edge
  // ------------------------------------------
  always @(negedge clk) begin
    if (root_g && !rq) r_rise++;
    if (bclk_g && !bq) b_rise++;
    if (fs_g && !fq) f_rise++;
    b_hi += bclk_g;
    f_hi += fs_g;
    if (root_g) root_hi++;
    else if (root_hi != 0) begin
      `check_eq(root_hi, 2)
      root_hi = 0;
    end
    if (fs_g !== fq) begin
      if (fs_run >= 0) `check_eq(fs_run >= 16, 1'b1)
      fs_run = 0;
    end
    fs_run += (fs_run >= 0);
    rq = root_g;
    bq = bclk_g;
    fq = fs_g;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      stop_test();
    end
  end

  // ------------------------------------------
  // bus tasks and reference model
  // ------------------------------------------
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (a == `CCG_OFF_STS || a == `CCG_OFF_ICLR) sts &= ~d;
    if (a == `CCG_OFF_CEN) cen = d & 32'h0000_000f;
    if (a == `CCG_OFF_IEN) ien = d & 32'ha000_0000;
  endtask

  task automatic rd_chk(input logic [11:0] a);
    logic [31:0] e;
    e = (a == `CCG_OFF_STS) ? sts : (a == `CCG_OFF_CEN) ? cen :
        (a == `CCG_OFF_IEN) ? ien : 32'h0;
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 `check_eq(rdata, e)
    `check_eq(irq, |(sts & ien))
    @(posedge clk);
  endtask

  // reserved bits get random values so stray decoding shows up
  task automatic set_cen(input logic [3:0] v);
    wr_reg(`CCG_OFF_CEN, ($urandom & 32'hffff_fff0) | {28'h0, v});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic span(input int n);
    @(posedge clk);
    r_rise = 0;
    b_rise = 0;
    f_rise = 0;
    b_hi = 0;
    f_hi = 0;
    repeat (n) @(posedge clk);
  endtask

  task automatic stop_test();
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------
  // main sequence
  // ------------------------------------------
  initial begin
    void'($urandom(32'h4a0b));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (offs[i]) rd_chk(offs[i]);
    foreach (offs[i]) wr_reg(offs[i], $urandom & 32'h5fff_fff0);
    foreach (offs[i]) rd_chk(offs[i]);
    wr_reg(`CCG_OFF_IEN, 32'ha000_0000);
    empty <= 1'b1;
    idle(4);
    sts[29] = 1'b1;
    rd_chk(`CCG_OFF_STS);
    wr_reg(`CCG_OFF_STS, $urandom & 32'h5fff_ffff);
    rd_chk(`CCG_OFF_STS);
    wr_reg(`CCG_OFF_IEN, 32'h0);
    rd_chk(`CCG_OFF_STS);
    wr_reg(`CCG_OFF_IEN, 32'ha000_0000);
    wr_reg(`CCG_OFF_STS, 32'h2000_0000);
    rd_chk(`CCG_OFF_STS);
    empty <= 1'b0;
    dmode <= 1'b1;
    idle(4);
    empty <= 1'b1;
    idle(4);
    rd_chk(`CCG_OFF_STS);
    ddone <= 1'b1;
    idle(4);
    sts[29] = 1'b1;
    rd_chk(`CCG_OFF_STS);
    wr_reg(`CCG_OFF_ICLR, 32'h2000_0000);
    for (int e = 0; e < 2; e++) begin
      lvl <= (e == 0);
      idle(8);
      set_cen((e == 1) ? 4'h8 : 4'h0);
      wr_reg((e == 1) ? `CCG_OFF_STS : `CCG_OFF_ICLR, 32'h8000_0000);
      lvl <= (e == 1);
      idle(8);
      rd_chk(`CCG_OFF_STS);
      lvl <= (e == 0);
      idle(8);
      sts[31] = 1'b1;
      rd_chk(`CCG_OFF_STS);
    end
    set_cen(4'h1);
    span(40);
    `check_eq(r_rise > 0, 1'b1)
    set_cen(4'h0);
    idle(6);
    span(40);
    `check_eq(r_rise + root_hi, 0)
    bdir <= 1'b1;
    idle(8);
    set_cen(4'h2);
    span(40);
    `check_eq(b_rise > 0, 1'b1)
    set_cen(4'h0);
    idle(12);
    span(40);
    `check_eq(b_hi, 40)
    set_cen(4'h2);
    idle(12);
    bdir <= 1'b0;
    set_cen(4'h0);
    idle(12);
    span(40);
    `check_eq(b_rise > 0, 1'b1)
    bdir <= 1'b1;
    idle(12);
    span(40);
    `check_eq(b_hi, 40)
    fdir <= 1'b1;
    set_cen(4'h4);
    wr_reg(`CCG_OFF_ICLR, 32'h8000_0000);
    span(80);
    `check_eq(f_rise > 0, 1'b1)
    sts[31] = 1'b1;
    rd_chk(`CCG_OFF_STS);
    set_cen(4'h0);
    idle(40);
    span(40);
    `check_eq(f_hi, 0)
    set_cen(4'h4);
    idle(40);
    fstop <= 1'b1;
    set_cen(4'h0);
    idle(40);
    span(40);
    `check_eq(f_hi, 40)
    stop_test();
  end
endmodule
